// ==== hw/mbp_defs.svh ====
// Constants for the match based pwm unit
`ifndef MBP_DEFS_SVH
`define MBP_DEFS_SVH

`define MBP_CNT_W      32
`define MBP_NUM_MATCH  7
`define MBP_NUM_OUT    6
`define MBP_CNT_ZERO   32'h0000_0000
`define MBP_CNT_ONE    32'h0000_0001
`define MBP_PERIOD_IDX 0

`endif

// ==== hw/mbp_pkg.sv ====
// Types shared by the match based pwm unit
`include "mbp_defs.svh"

package mbp_pkg;

   // Per match register action selection
   typedef struct packed {
      logic irq_en;
      logic reset_en;
      logic stop_en;
   } mbp_match_ctrl_t;

   // Unit level control levels
   typedef struct packed {
      logic cnt_enable;
      logic cnt_reset;
      logic pwm_enable;
   } mbp_ctrl_t;

   typedef logic [`MBP_NUM_MATCH-1:0][`MBP_CNT_W-1:0] mbp_match_vals_t;
   typedef mbp_match_ctrl_t [`MBP_NUM_MATCH-1:0]      mbp_match_ctrls_t;

   // Counter run state, Gray coded along idle, run, halt
   typedef enum logic [1:0] {
      MBP_IDLE = 2'h0,
      MBP_RUN  = 2'h1,
      MBP_HALT = 2'h3
   } mbp_state_t;

endpackage : mbp_pkg

// ==== hw/mbp_match_slot.sv ====
// One match register with shadow release and compare
`timescale 1ns/1ns
`default_nettype none
`include "mbp_defs.svh"

module mbp_match_slot
   import mbp_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic [`MBP_CNT_W-1:0] shadow_val,
   input  wire logic                 release_req,
   input  wire logic                 apply,
   input  wire logic [`MBP_CNT_W-1:0] count,
   input  wire logic                 tick,
   output logic      [`MBP_CNT_W-1:0] active_val,
   output logic                      pending,
   output logic                      hit
);

   logic [`MBP_CNT_W-1:0] active_reg;
   logic                  pending_reg;

   // Released value waits for the apply strobe before it goes live
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pending_reg <= 1'b0;
      end else if (release_req && !apply) begin
         pending_reg <= 1'b1;                 // [R10]
      end else if (apply) begin
         pending_reg <= 1'b0;
      end
   end

   // Active compare value loads only on apply
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         active_reg <= `MBP_CNT_ZERO;
      end else if (apply && (pending_reg || release_req)) begin
         active_reg <= shadow_val;            // [R10]
      end
   end

   assign active_val = active_reg;
   assign pending    = pending_reg;
   // Compare only on counter advance so one count gives one hit
   assign hit        = tick && (count == active_reg);

endmodule // mbp_match_slot
`default_nettype wire

// ==== hw/mbp_top.sv ====
// Match based pwm unit: prescaler, counter, seven matches, six outputs
//
// Notes on behaviour
// [R1] Counter advances, compared against seven matches
// [R2] Per match optional interrupt request pulse
// [R3] Stop on match halts the counter
// [R4] Reset on match zeroes counter, keeps counting
// [R5] Period match sets the common cycle
// [R6] Single edge output uses one extra match
// [R7] Single edge outputs rise at period match
// [R8] Double edge output uses two extra matches
// [R9] Rise before fall positive, else negative
// [R10] Released match values apply at cycle start
// [R11] Constant low single edge stays low
// [R12] 32 bit counter with 32 bit prescaler
// [R13] Without pwm mode acts as plain timer
// [R14] Prescaler wraps at limit, advances counter
// [R15] Reset leaves everything zero and disabled
`timescale 1ns/1ns
`default_nettype none
`include "mbp_defs.svh"

module mbp_top
   import mbp_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire mbp_ctrl_t                ctrl,
   input  wire logic [`MBP_CNT_W-1:0]    prescale_limit,
   input  wire mbp_match_vals_t          match_shadow,
   input  wire logic [`MBP_NUM_MATCH-1:0] match_release,
   input  wire mbp_match_ctrls_t         match_ctrl,
   input  wire logic [`MBP_NUM_OUT-1:0]  dbl_edge_sel,
   input  wire logic [`MBP_NUM_OUT-1:0]  out_enable,
   output logic      [`MBP_NUM_OUT-1:0]  pwm_out,
   output logic      [`MBP_NUM_MATCH-1:0] match_irq,
   output logic      [`MBP_NUM_MATCH-1:0] release_pending,
   output logic      [`MBP_CNT_W-1:0]    timer_count,
   output logic      [`MBP_CNT_W-1:0]    prescale_count,
   output mbp_state_t                    cnt_state
);

   // Next level of an edge controlled output; clear beats set
   function automatic logic edge_next(input logic set_c, input logic clr_c,
                                      input logic cur);
      if (clr_c) begin
         return 1'b0;
      end else if (set_c) begin
         return 1'b1;
      end
      return cur;
   endfunction

   // Counter increment at full width
   function automatic logic [`MBP_CNT_W-1:0] inc_cnt(input logic [`MBP_CNT_W-1:0] v);
      return v + `MBP_CNT_ONE;
   endfunction

   logic [`MBP_CNT_W-1:0]    pre_reg;
   logic [`MBP_CNT_W-1:0]    cnt_reg;
   mbp_state_t               state_reg;
   mbp_state_t               state_next;
   logic [`MBP_NUM_OUT-1:0]  out_reg;
   logic [`MBP_NUM_OUT-1:0]  out_next;
   logic [`MBP_NUM_MATCH-1:0] irq_reg;
   logic [`MBP_NUM_MATCH-1:0] hit;
   logic [`MBP_NUM_MATCH-1:0] pend;
   mbp_match_vals_t          active;
   logic                     running;
   logic                     tick;
   logic                     stop_hit;
   logic                     reset_hit;
   logic                     period_hit;
   logic                     apply;

   // Counter only runs in the run state and outside soft reset
   assign running = (state_reg == MBP_RUN) && !ctrl.cnt_reset;
   // Prescaler terminal count gives one counter advance
   assign tick    = running && (pre_reg == prescale_limit);      // [R14]

   // Stop and reset requests collected from all matches
   always_comb begin
      stop_hit  = 1'b0;
      reset_hit = 1'b0;
      for (int i = 0; i < `MBP_NUM_MATCH; i++) begin
         stop_hit  = stop_hit  | (hit[i] & match_ctrl[i].stop_en);   // [R3]
         reset_hit = reset_hit | (hit[i] & match_ctrl[i].reset_en);  // [R4]
      end
   end

   // Period match marks the start of each pwm cycle
   assign period_hit = hit[`MBP_PERIOD_IDX];                     // [R5]
   // Released values go live at cycle start in pwm mode, at once otherwise
   assign apply      = ctrl.pwm_enable ? period_hit : 1'b1;      // [R10] [R13]

   // Seven match slots compared against the counter
   for (genvar g = 0; g < `MBP_NUM_MATCH; g++) begin : g_slot
      mbp_match_slot u_slot (
         .sys_clk     (sys_clk),
         .rst_n       (rst_n),
         .shadow_val  (match_shadow[g]),
         .release_req (match_release[g]),
         .apply       (apply),
         .count       (cnt_reg),
         .tick        (tick),
         .active_val  (active[g]),
         .pending     (pend[g]),
         .hit         (hit[g])                                   // [R1]
      );
   end

   // Prescaler counts clocks and wraps at its limit
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pre_reg <= `MBP_CNT_ZERO;                               // [R15]
      end else if (!running) begin
         pre_reg <= `MBP_CNT_ZERO;
      end else if (tick) begin
         pre_reg <= `MBP_CNT_ZERO;                               // [R14]
      end else begin
         pre_reg <= inc_cnt(pre_reg);                            // [R12]
      end
   end

   // Main counter: reset on match wins, stop holds, else advance
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_reg <= `MBP_CNT_ZERO;                               // [R15]
      end else if (ctrl.cnt_reset) begin
         cnt_reg <= `MBP_CNT_ZERO;
      end else if (reset_hit) begin
         cnt_reg <= `MBP_CNT_ZERO;                               // [R4]
      end else if (stop_hit) begin
         cnt_reg <= cnt_reg;                                     // [R3]
      end else if (tick) begin
         cnt_reg <= inc_cnt(cnt_reg);                            // [R1] [R12]
      end
   end

   // Run state follows enable; a stop match parks it in halt
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         MBP_IDLE: begin
            if (ctrl.cnt_enable) begin
               state_next = MBP_RUN;
            end
         end
         MBP_RUN: begin
            if (!ctrl.cnt_enable) begin
               state_next = MBP_IDLE;
            end else if (stop_hit) begin
               state_next = MBP_HALT;                            // [R3]
            end
         end
         MBP_HALT: begin
            if (!ctrl.cnt_enable) begin
               state_next = MBP_IDLE;
            end
         end
         default: begin
            state_next = MBP_IDLE;
         end
      endcase
   end

   // Run state register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= MBP_IDLE;                                  // [R15]
      end else begin
         state_reg <= state_next;
      end
   end

   // Output n uses match n for fall; double edge adds match n-1 for rise
   always_comb begin
      out_next = out_reg;
      for (int n = 1; n <= `MBP_NUM_OUT; n++) begin
         if (!ctrl.pwm_enable || !out_enable[n-1]) begin
            out_next[n-1] = 1'b0;                                // [R13]
         end else if (dbl_edge_sel[n-1] && n >= 2) begin
            // Rise and fall placed freely; order sets pulse polarity
            out_next[n-1] = edge_next(hit[n-1], hit[n], out_reg[n-1]); // [R8] [R9]
         end else begin
            // Single edge outputs rise together at period match, except those whose match value is zero
            out_next[n-1] = edge_next(period_hit, hit[n], out_reg[n-1]); // [R6] [R7]
            if (active[n] == `MBP_CNT_ZERO) begin
               out_next[n-1] = 1'b0;                             // [R11]
            end
         end
      end
   end

   // Registered pwm outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_reg <= '0;                                          // [R15]
      end else begin
         out_reg <= out_next;
      end
   end

   // Interrupt request pulse for each enabled match
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_reg <= '0;
      end else begin
         for (int i = 0; i < `MBP_NUM_MATCH; i++) begin
            irq_reg[i] <= hit[i] & match_ctrl[i].irq_en;         // [R2]
         end
      end
   end

   assign pwm_out         = out_reg;
   assign match_irq       = irq_reg;
   assign release_pending = pend;
   assign timer_count     = cnt_reg;
   assign prescale_count  = pre_reg;
   assign cnt_state       = state_reg;

endmodule // mbp_top
`default_nettype wire

// ==== verif/mbp_load_model.sv ====
// Load model: integrates on time of each pwm output over a window
`timescale 1ns/1ns
`default_nettype none
`include "mbp_defs.svh"

module mbp_load_model
(
   input  wire logic                        sys_clk,
   input  wire logic [`MBP_NUM_OUT-1:0]     pwm_out,
   input  wire logic                        window,
   output logic      [`MBP_NUM_OUT-1:0][7:0] on_cycles
);
   // Count high cycles while the window is open, clear when it closes
   always_ff @(posedge sys_clk) begin
      for (int n = 0; n < `MBP_NUM_OUT; n++) begin
         on_cycles[n] <= window ? on_cycles[n] + 8'(pwm_out[n]) : 8'h00;
      end
   end
endmodule // mbp_load_model
`default_nettype wire

// ==== verif/mbp_checker_assertions.sv ====
// Concurrent checks on the ports of the match based pwm unit
`timescale 1ns/1ns
`default_nettype none
`include "mbp_defs.svh"

module mbp_checker
   import mbp_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire mbp_ctrl_t                 ctrl,
   input  wire logic [`MBP_CNT_W-1:0]     prescale_limit,
   input  wire logic [`MBP_NUM_MATCH-1:0] match_release,
   input  wire mbp_match_ctrls_t          match_ctrl,
   input  wire logic [`MBP_NUM_OUT-1:0]   pwm_out,
   input  wire logic [`MBP_NUM_MATCH-1:0] match_irq,
   input  wire logic [`MBP_NUM_MATCH-1:0] release_pending,
   input  wire logic [`MBP_CNT_W-1:0]     timer_count,
   input  wire logic [`MBP_CNT_W-1:0]     prescale_count,
   input  wire mbp_state_t                cnt_state
);
   logic tick;
   logic go;
   // Prescaler tick as seen at the ports
   assign tick = cnt_state == MBP_RUN && !ctrl.cnt_reset && prescale_count == prescale_limit;
   assign go   = tick && ctrl.cnt_enable;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> pwm_out == '0 &&
      match_irq == '0 && cnt_state == MBP_IDLE && timer_count == '0) else $error("reset state wrong");
   timer_mode_a: assert property (!ctrl.pwm_enable |=> pwm_out == '0)
      else $error("output active in timer mode");
   no_tick_hold_a: assert property (cnt_state == MBP_RUN && ctrl.cnt_enable && !ctrl.cnt_reset
      && !tick |=> $stable(timer_count) && prescale_count == $past(prescale_count) + 1)
      else $error("counter moved without tick");
   prescale_wrap_a: assert property (go |=> prescale_count == '0)
      else $error("prescaler did not wrap");
   count_step_a: assert property (go |=> timer_count == $past(timer_count) + 1
      || timer_count == '0 || cnt_state == MBP_HALT) else $error("bad counter step");
   cnt_reset_a: assert property (ctrl.cnt_reset |=> timer_count == '0 && prescale_count == '0)
      else $error("counter not held at zero");
   halt_hold_a: assert property (cnt_state == MBP_HALT && ctrl.cnt_enable && !ctrl.cnt_reset
      |=> $stable(timer_count) && cnt_state == MBP_HALT) else $error("halted counter moved");
   irq_cause_a: assert property (|match_irq |-> $past(tick))
      else $error("interrupt without match");
   // With reset on match 0 set, period match restarts the count in pwm mode, so a release may go live only where the
   // count comes back to zero; this holds at any prescale setting
   pending_keep_a: assert property (ctrl.pwm_enable && match_ctrl[0].reset_en |=>
      ($past(release_pending) & ~release_pending) == '0 || timer_count == '0)
      else $error("release applied mid cycle");
   pending_set_a: assert property (ctrl.pwm_enable && match_ctrl[0].reset_en |=>
      (release_pending & $past(match_release)) == $past(match_release) || timer_count == '0)
      else $error("release lost");

   halt_c: cover property (cnt_state == MBP_HALT);
   irq_c: cover property (match_irq[0]);
   pending_c: cover property ($fell(release_pending[1]));
   rise_c: cover property ($rose(pwm_out[5]));
endmodule // mbp_checker
`default_nettype wire

bind mbp_top mbp_checker mbp_checker_i (.sys_clk, .rst_n, .ctrl, .prescale_limit, .match_release,
   .match_ctrl,
   .pwm_out, .match_irq, .release_pending, .timer_count, .prescale_count, .cnt_state);

// ==== verif/tb_top.sv ====
// Self-checking testbench for the match based pwm unit
`timescale 1ns/1ns
`default_nettype none
`include "mbp_defs.svh"

module tb_top;
   import mbp_pkg::*;
   logic                             sys_clk = 1'b0;
   logic                             rst_n = 1'b0;
   mbp_ctrl_t                        ctrl = '0;
   logic [`MBP_CNT_W-1:0]            prescale_limit = '0;
   mbp_match_vals_t                  match_shadow = '0;
   logic [`MBP_NUM_MATCH-1:0]        match_release = '0;
   mbp_match_ctrls_t                 match_ctrl = '0;
   logic [`MBP_NUM_OUT-1:0]          dbl_edge_sel = '0;
   logic [`MBP_NUM_OUT-1:0]          out_enable = '0;
   logic [`MBP_NUM_OUT-1:0]          pwm_out;
   logic [`MBP_NUM_MATCH-1:0]        match_irq;
   logic [`MBP_NUM_MATCH-1:0]        release_pending;
   logic [`MBP_CNT_W-1:0]            timer_count;
   logic [`MBP_CNT_W-1:0]            prescale_count;
   mbp_state_t                       cnt_state;
   logic                             window = 1'b0;
   logic [`MBP_NUM_OUT-1:0][7:0]     on_cycles;
   int                               bad_count = 0;
   int                               cmp_count = 0;
   int                               cycles = 0;
   int                               irq_seen = 0;
   int                               gap;

   always #25 sys_clk = ~sys_clk;

   mbp_top mbp_top_i (.sys_clk, .rst_n, .ctrl, .prescale_limit, .match_shadow, .match_release,
      .match_ctrl, .dbl_edge_sel, .out_enable, .pwm_out, .match_irq, .release_pending,
      .timer_count, .prescale_count, .cnt_state);
   mbp_load_model mbp_load_model_i (.sys_clk, .pwm_out, .window, .on_cycles);

   task automatic finish_test();
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // One cycle release pulse
   task automatic release_sel(input logic [`MBP_NUM_MATCH-1:0] m);
      match_release = m;
      step(1);
      match_release = '0;
   endtask

   // Four periods of eight counts, on time per output compared
   task automatic measure(input logic [`MBP_NUM_OUT-1:0][7:0] exp);
      window = 1'b1;
      step(32);
      window = 1'b0;
      for (int n = 0; n < `MBP_NUM_OUT; n++) chk(32'(on_cycles[n]), 32'(exp[n]) * 4, "on time");
   endtask

   // Cycle ceiling and interrupt pulse count
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (match_irq[0] === 1'b1) irq_seen <= irq_seen + 1;
      if (cycles == 1000) begin
         bad_count++;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      step(2);
      rst_n = 1'b1;
      chk(32'(pwm_out), 0, "idle out");
      chk(32'(cnt_state), 32'(MBP_IDLE), "idle state");
      match_shadow = {32'h1, 32'h6, 32'h6, 32'h2, 32'h0, 32'h5, 32'h7};
      match_ctrl[0].reset_en = 1'b1;
      release_sel(7'h7F);
      out_enable = 6'h2F;
      dbl_edge_sel = 6'h28;
      ctrl.pwm_enable = 1'b1;
      ctrl.cnt_enable = 1'b1;
      step(24);
      measure({8'h03, 8'h00, 8'h04, 8'h03, 8'h00, 8'h06});
      while (timer_count !== 32'h1) step(1);
      match_shadow[1] = 32'h3;
      release_sel(7'h02);
      chk(32'(release_pending[1]), 1, "pending held");
      step(10);
      chk(32'(release_pending[1]), 0, "pending applied");
      step(14);
      measure({8'h03, 8'h00, 8'h04, 8'h03, 8'h00, 8'h04});
      ctrl.pwm_enable = 1'b0;
      step(2);
      chk(32'(pwm_out), 0, "timer mode");
      ctrl.cnt_enable = 1'b0;
      ctrl.cnt_reset = 1'b1;
      match_ctrl[0] = 3'b101;
      prescale_limit = 32'h0000_0002;
      step(2);
      irq_seen = 0;
      ctrl.cnt_reset = 1'b0;
      ctrl.cnt_enable = 1'b1;
      while (timer_count !== 32'h2) step(1);
      gap = 0;
      while (timer_count === 32'h2) begin
         step(1);
         gap++;
      end
      chk(32'(gap), 3, "prescale gap");
      step(30);
      chk(32'(cnt_state), 32'(MBP_HALT), "halt state");
      chk(timer_count, 32'h7, "halt count");
      chk(32'(irq_seen), 1, "irq pulses");
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      chk(timer_count, 0, "count after reset");
      chk(32'(cnt_state), 32'(MBP_IDLE), "state after reset");
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
